/* rtl/aux_port_pkg.sv */
// Constants for the auxiliary pin port register block
package aux_port_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    localparam int          PINS            = 4;
    // Register indices, and byte addresses (register index times four)
    localparam logic [7:0]  IDX_CONNECT_DIR = 8'h04;
    localparam logic [7:0]  IDX_DATA_STAT   = 8'h05;
    localparam logic [7:0]  ADDR_CONNECT_DIR = IDX_CONNECT_DIR << 2;
    localparam logic [7:0]  ADDR_DATA_STAT  = IDX_DATA_STAT << 2;
    // Field positions
    localparam int          ATTACH_LSB      = 4;
    localparam int          DIR_LSB         = 0;
    localparam int          LEVEL_LSB       = 0;
    localparam int          STATUS_INC_BIT  = 6;
    // Reset values
    localparam logic [7:0]  CONNECT_DIR_RST = 8'h00;
    localparam logic [7:0]  DATA_STAT_RST   = 8'h00;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : aux_port_pkg

/* rtl/aux_pin_drive.sv */
// Pin driver: enables and read-back for the four auxiliary pins
`timescale 1ns/1ps
module aux_pin_drive #(
    parameter int PINS = 4
) (
    // Control from registers
    input  wire logic [PINS-1:0] pin_attach_bits,
    input  wire logic [PINS-1:0] pin_dir_input,
    input  wire logic [PINS-1:0] pin_drive_level,
    // Pins
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe,
    // Read-back
    output logic      [PINS-1:0] pin_level_seen
);
    always_comb begin
        pin_oe  = pin_attach_bits & ~pin_dir_input;
        pin_out = pin_drive_level & pin_oe;
        // Detached pins read back zero, driven pins read their own level
        pin_level_seen = pin_attach_bits & ((pin_oe & pin_drive_level) | (~pin_oe & pin_in));
    end
endmodule : aux_pin_drive

/* rtl/adc_aux_pin_port.sv */
// Auxiliary pin port with AXI4-Lite register access
//
// How it works
// - Upper nibble of connect register attaches each port bit to its pin.
// - Port bit 1 uses the negative-reference alternate pin, attach bit 5.
// - Port bit 0 uses the positive-reference alternate pin, attach bit 4.
// - Lower nibble direction bits: 0 makes output, 1 makes input.
// - Data bits read the pin level and set the driven level.
// - Bit 6 of data register includes the status byte in data reads.
// - After reset every field of both registers reads zero.
// - Data register sits at index 05h, resets to 00h.
// - Connect register sits at index 04h, resets to 00h.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module adc_aux_pin_port
    import aux_port_pkg::*;
#(
    parameter int PIN_COUNT = 4
) (
    // Clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // AXI4-Lite write address
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [aux_port_pkg::ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    input  wire logic [aux_port_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    output logic      [1:0]                      s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    input  wire logic [aux_port_pkg::ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    output logic      [aux_port_pkg::DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]                      s_axi_rresp,
    // Auxiliary pins: bit 0 positive-ref alt, bit 1 negative-ref alt
    input  wire logic [PIN_COUNT-1:0]            pin_in,
    output logic      [PIN_COUNT-1:0]            pin_out,
    output logic      [PIN_COUNT-1:0]            pin_oe,
    // To the conversion read path
    output logic                                 status_byte_include
);
    import aux_port_pkg::*;

    logic [7:0]           connect_dir_ff;
    logic [7:0]           data_stat_ff;
    logic [ADDR_W-1:0]    awaddr_ff;
    logic                 aw_held_ff;
    logic [DATA_W-1:0]    wdata_ff;
    logic                 wstrb0_ff;
    logic                 w_held_ff;
    logic                 bvalid_ff;
    logic [1:0]           bresp_ff;
    logic                 rvalid_ff;
    logic [DATA_W-1:0]    rdata_ff;
    logic [1:0]           rresp_ff;
    logic [PIN_COUNT-1:0] pin_level_seen;
    logic                 do_write;
    logic                 ar_take;

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = (a == ADDR_CONNECT_DIR) || (a == ADDR_DATA_STAT);
    endfunction : addr_known

    // One write and one read in flight; hold channels until response drains
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= '0;
            wstrb0_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    // Register writes; only byte lane 0 carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            connect_dir_ff <= CONNECT_DIR_RST;
            data_stat_ff   <= DATA_STAT_RST;
        end else if (do_write && wstrb0_ff) begin
            if (awaddr_ff == ADDR_CONNECT_DIR) begin
                connect_dir_ff <= wdata_ff[7:0];
            end
            if (awaddr_ff == ADDR_DATA_STAT) begin
                // Reserved bits kept zero even if host breaks the convention
                data_stat_ff <= {1'b0, wdata_ff[STATUS_INC_BIT], 2'b00,
                                 wdata_ff[LEVEL_LSB +: 4]};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= addr_known(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read path: data bits show pin state, not the written value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == ADDR_CONNECT_DIR) begin
                rdata_ff <= {24'h000000, connect_dir_ff};
            end else if (s_axi_araddr == ADDR_DATA_STAT) begin
                rdata_ff <= {24'h000000, data_stat_ff[7:4],
                             pin_level_seen};
            end else begin
                rdata_ff <= '0;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
    assign status_byte_include = data_stat_ff[STATUS_INC_BIT];

    // Bit n of the attach nibble serves pin n: bit 4 pin 0, bit 5 pin 1
    aux_pin_drive #(
        .PINS (PIN_COUNT)
    ) u_drive (
        .pin_attach_bits (connect_dir_ff[ATTACH_LSB +: PIN_COUNT]),
        .pin_dir_input   (connect_dir_ff[DIR_LSB +: PIN_COUNT]),
        .pin_drive_level (data_stat_ff[LEVEL_LSB +: PIN_COUNT]),
        .pin_in          (pin_in),
        .pin_out         (pin_out),
        .pin_oe          (pin_oe),
        .pin_level_seen  (pin_level_seen)
    );
endmodule : adc_aux_pin_port

/* bench/aux_pin_far_model.sv */
// Far-side pin circuitry model for the auxiliary pins
`timescale 1ns/1ps
module aux_pin_far_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] ext_level,
    output logic      [3:0] pin_in
);
    // Undriven pins take the external circuit's level
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : aux_pin_far_model

/* bench/adc_aux_pin_port_chk.sv */
// Assertion checker for the auxiliary pin port
`timescale 1ns/1ps
module adc_aux_pin_port_chk
    import aux_port_pkg::*;
#(parameter int PIN_COUNT = 4) (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, status_byte_include,
    input wire logic [aux_port_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [aux_port_pkg::DATA_W-1:0] s_axi_wdata, s_axi_rdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [PIN_COUNT-1:0] pin_out, pin_oe
);
    wire wg = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    wire rg = s_axi_arvalid && s_axi_arready;
    wire rm = s_axi_araddr == ADDR_DATA_STAT || s_axi_araddr == ADDR_CONNECT_DIR;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    oe_gate_a: assert property ((pin_out & ~pin_oe) == '0)
        else $error("pin driven high while off");
    reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> pin_oe == '0 && !status_byte_include)
        else $error("not clear after reset");
    map_read_a: assert property (rg && rm |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
        else $error("mapped read refused");
    unmap_read_a: assert property (rg && !rm |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read accepted");
    status_read_a: assert property (rg && s_axi_araddr == ADDR_DATA_STAT |=>
        s_axi_rdata[6] == status_byte_include && {s_axi_rdata[31:7], s_axi_rdata[5:4]} == '0)
        else $error("status bit read wrong");
    // Register lands two edges after the handshake: one to hold, one to write
    status_write_a: assert property (wg && s_axi_awaddr == ADDR_DATA_STAT |-> ##2
        status_byte_include == $past(s_axi_wdata[6], 2))
        else $error("status bit not written");
    oe_write_a: assert property (wg && s_axi_awaddr == ADDR_CONNECT_DIR |-> ##2
        pin_oe == ($past(s_axi_wdata[7:4], 2) & ~$past(s_axi_wdata[3:0], 2)))
        else $error("drive enable wrong");
    pin_readback_a: assert property (rg && s_axi_araddr == ADDR_DATA_STAT |=>
        ((s_axi_rdata[3:0] ^ $past(pin_out)) & $past(pin_oe)) == '0)
        else $error("driven level read wrong");
    cover property (rg && !rm);
    cover property (status_byte_include);
    cover property (pin_oe == 4'hc);
endmodule : adc_aux_pin_port_chk
bind adc_aux_pin_port adc_aux_pin_port_chk #(.PIN_COUNT(PIN_COUNT)) chk_u (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .status_byte_include, .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata,
    .s_axi_rdata, .s_axi_wstrb, .s_axi_rresp, .pin_out, .pin_oe);

/* bench/adc_aux_pin_port_tb.sv */
// Self-checking bench for the auxiliary pin port
`timescale 1ns/1ps
module adc_aux_pin_port_tb;
    import aux_port_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic status_byte_include;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, pin_in, pin_out, pin_oe, ext_level;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares = 0;
    int check_count = 0;
    adc_aux_pin_port dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_in, .pin_out, .pin_oe,
        .status_byte_include);
    aux_pin_far_model far_u (.pin_out, .pin_oe, .ext_level, .pin_in);
    task chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 20);
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid) begin
            chk(s_axi_bresp, r);
        end else begin
            miscompares++;
            $display("wrong value at %0t: write response timed out", $time);
            tally_and_finish;
        end
    endtask : axw
    task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 20);
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid) begin
            chk(s_axi_rresp, r);
            chk(s_axi_rdata, d);
        end else begin
            miscompares++;
            $display("wrong value at %0t: read response timed out", $time);
            tally_and_finish;
        end
    endtask : axr
    task t_pins;
        int i;
        axw(ADDR_DATA_STAT, 32'h0f, 4'hf, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            axw(ADDR_CONNECT_DIR, 32'h10 << i, 4'hf, RESP_OKAY);
            chk({pin_oe, pin_out}, {4'h1 << i, 4'h1 << i});
            axw(ADDR_CONNECT_DIR, 32'h11 << i, 4'hf, RESP_OKAY);
            chk(pin_oe, 4'h0);
        end
        $display("t_pins done");
    endtask : t_pins
    task t_levels;
        ext_level <= 4'ha;
        axw(ADDR_CONNECT_DIR, 32'h3f, 4'hf, RESP_OKAY);
        axr(ADDR_DATA_STAT, 32'h02, RESP_OKAY);
        axw(ADDR_CONNECT_DIR, 32'hc3, 4'hf, RESP_OKAY);
        axw(ADDR_CONNECT_DIR, 32'h00, 4'h0, RESP_OKAY);
        axr(ADDR_CONNECT_DIR, 32'hc3, RESP_OKAY);
        axr(ADDR_DATA_STAT, 32'h0c, RESP_OKAY);
        $display("t_levels done");
    endtask : t_levels
    task t_status;
        axw(ADDR_DATA_STAT, 32'h4f, 4'hf, RESP_OKAY);
        chk(status_byte_include, 1'b1);
        axr(ADDR_DATA_STAT, 32'h4c, RESP_OKAY);
        axw(8'h05, 32'h00, 4'hf, RESP_SLVERR);
        axr(8'h04, 32'h00, RESP_SLVERR);
        axw(ADDR_DATA_STAT, 32'h0f, 4'hf, RESP_OKAY);
        chk(status_byte_include, 1'b0);
        $display("t_status done");
    endtask : t_status
    // Reset in mid-run, with pins 2 and 3 driven and status bit written back to 0 before it
    task t_reset;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk({pin_oe, pin_out, status_byte_include}, 9'h0);
        axr(ADDR_CONNECT_DIR, 32'h0, RESP_OKAY);
        axr(ADDR_DATA_STAT, 32'h0, RESP_OKAY);
        $display("t_reset done");
    endtask : t_reset
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ext_level} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axr(ADDR_CONNECT_DIR, 32'h0, RESP_OKAY);
        axr(ADDR_DATA_STAT, 32'h0, RESP_OKAY);
        chk({pin_oe, status_byte_include}, 5'h0);
        t_pins;
        t_levels;
        t_status;
        t_reset;
        tally_and_finish;
    end
endmodule : adc_aux_pin_port_tb
